// [dv/pmr_host_model.sv]
`timescale 1ns/1ns
module pmr_host_model (
    // Clock and resolved data line.
    input  wire        clk,
    input  wire        mdio_line,
    // Serial clock and host data level; a one also stands for a released line.
    output reg         mdc,
    output reg         host_drive,
    // Read result strobe.
    output reg         rd_valid,
    output reg  [15:0] rd_data
);
    initial begin
        mdc = 1'b0;
        host_drive = 1'b1;
        rd_valid = 1'b0;
        rd_data = 16'h0000;
    end

    // One bit: data set while mdc is low, sampled just before it rises; halves of 8 clocks keep the
    // slow three-flop sampling of the device well inside its window.
    task automatic bit_cycle(input logic b, output logic s);
        host_drive <= b;
        repeat (8) @(posedge clk);
        s = mdio_line;
        mdc <= 1'b1;
        repeat (8) @(posedge clk);
        mdc <= 1'b0;
    endtask

    // Whole frame with its own preamble; a read releases the line from the turnaround on.
    task automatic frame(input [1:0] op, input [4:0] pa, input [4:0] ra, input [15:0] wd,
                         output [15:0] rd);
        logic [63:0] f;
        logic        s;
        int          i;
        f = {32'hffffffff, 2'b01, op, pa, ra, (op == 2'h2) ? 18'h3ffff : {2'b10, wd}};
        for (i = 63; i >= 0; i--) begin
            bit_cycle(f[i], s);
            if (i < 16) rd[i] = s;
        end
        // Release the line and let one edge pass, so that a following frame never assigns it again in this step.
        host_drive <= 1'b1;
        if (op == 2'h2) begin
            rd_data <= rd;
            rd_valid <= 1'b1;
        end
        @(posedge clk);
        rd_valid <= 1'b0;
    endtask
endmodule // pmr_host_model

// [dv/pmr_register_set_assertions.sv]
`timescale 1ns/1ns
module pmr_register_set_checker #(
    parameter FORCED_SPEED_100 = 1'b1
) (
    // Clock, reset and serial pins.
    input wire       clk,
    input wire       rst,
    input wire       mdc,
    input wire       mdio_in,
    input wire       mdio_out,
    input wire       mdio_oe,
    // Core state and control outputs.
    input wire       link_up,
    input wire       negotiation_done,
    input wire       remote_fault,
    input wire       negotiation_enable,
    input wire       renegotiate_request,
    input wire       negotiation_restart,
    input wire       forced_full_duplex,
    input wire       crossover_algorithm_select,
    input wire       fixed_pair_assignment,
    input wire       auto_crossover_off,
    input wire       remote_fault_detect_off,
    input wire       transmit_off,
    input wire       indicator_off,
    input wire       pause_advertise,
    input wire [3:0] ability_advertise,
    input wire       link_speed_100,
    input wire       link_full_duplex
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // The restart strobe is a single-cycle event and comes with the stored bit set.
    property p_restart_pulse; negotiation_restart |=> !negotiation_restart; endproperty
    a_restart_pulse: assert property (p_restart_pulse) else $error("restart pulse too long");
    property p_restart_sets; $rose(renegotiate_request) |-> negotiation_restart; endproperty
    a_restart_sets: assert property (p_restart_sets) else $error("restart bit set without pulse");
    // A read answer always opens with a driven zero turnaround bit.
    property p_ta_zero; $rose(mdio_oe) |-> !mdio_out; endproperty
    a_ta_zero: assert property (p_ta_zero) else $error("turnaround bit not zero");
    // Neither forced duplex, the abilities nor transmit off may move while the device is answering a read.
    property p_read_quiet;
        mdio_oe |-> $stable(forced_full_duplex) && $stable(ability_advertise) && $stable(transmit_off);
    endproperty
    a_read_quiet: assert property (p_read_quiet) else $error("field moved during read");
    // Resolved mode follows the advertisement while negotiation is on.
    property p_on_speed;
        negotiation_enable && $stable(negotiation_enable) && $stable(ability_advertise)
        |-> link_speed_100 == (ability_advertise[3] | ability_advertise[2]);
    endproperty
    a_on_speed: assert property (p_on_speed) else $error("speed not from advertisement");
    property p_on_full;
        negotiation_enable && $stable(negotiation_enable) && $stable(ability_advertise)
        |-> link_full_duplex == (ability_advertise[3] | (!ability_advertise[2] & ability_advertise[1]));
    endproperty
    a_on_full: assert property (p_on_full) else $error("duplex not from advertisement");
    property p_forced;
        !negotiation_enable && $stable(negotiation_enable) && $stable(forced_full_duplex)
        |-> link_speed_100 == FORCED_SPEED_100 && link_full_duplex == forced_full_duplex;
    endproperty
    a_forced: assert property (p_forced) else $error("forced mode not applied");
    // Reset values hold throughout reset; not disabled by reset on purpose.
    property p_reset_vals;
        disable iff (1'b0) rst && $past(rst) |-> negotiation_enable && !renegotiate_request
        && !negotiation_restart && forced_full_duplex && crossover_algorithm_select && !fixed_pair_assignment
        && !auto_crossover_off && !remote_fault_detect_off && !transmit_off && !indicator_off
        && pause_advertise && ability_advertise == 4'hf && !mdio_oe;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("wrong value in reset");
endmodule // pmr_register_set_checker

bind pmr_register_set pmr_register_set_checker #(.FORCED_SPEED_100(FORCED_SPEED_100)) u_chk (
    .clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .link_up(link_up), .negotiation_done(negotiation_done), .remote_fault(remote_fault),
    .negotiation_enable(negotiation_enable), .renegotiate_request(renegotiate_request),
    .negotiation_restart(negotiation_restart), .forced_full_duplex(forced_full_duplex),
    .crossover_algorithm_select(crossover_algorithm_select), .fixed_pair_assignment(fixed_pair_assignment),
    .auto_crossover_off(auto_crossover_off), .remote_fault_detect_off(remote_fault_detect_off),
    .transmit_off(transmit_off), .indicator_off(indicator_off), .pause_advertise(pause_advertise),
    .ability_advertise(ability_advertise), .link_speed_100(link_speed_100), .link_full_duplex(link_full_duplex));

// [dv/tb.sv]
`timescale 1ns/1ns
module tb;
    localparam [4:0] PA = 5'h04;
    reg         clk, rst, link_up, negotiation_done, remote_fault;
    wire        mdc, host_drive, rd_valid, mdio_out, mdio_oe, neg_en, reneg, restart, full, alg, pair, xoff;
    wire        fault_off, tx_off, led_off, pause, speed, duplex;
    wire [3:0]  ability;
    wire [15:0] rd_data;
    // Undriven line is pulled up; the host model's one level stands for that.
    wire        mdio_line = mdio_oe ? mdio_out : host_drive;
    integer     err_count, checked, exp_restarts, i;
    integer     cycles = 0;
    integer     restarts = 0;
    logic [15:0] exp_q[$];
    logic [15:0] ctl, adv, w, d;
    logic [2:0]  ls;

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    pmr_register_set #(.PORT_NUMBER(PA)) u_dut (
        .clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .link_up(link_up), .negotiation_done(negotiation_done), .remote_fault(remote_fault),
        .negotiation_enable(neg_en), .renegotiate_request(reneg), .negotiation_restart(restart),
        .forced_full_duplex(full), .crossover_algorithm_select(alg), .fixed_pair_assignment(pair),
        .auto_crossover_off(xoff), .remote_fault_detect_off(fault_off), .transmit_off(tx_off),
        .indicator_off(led_off), .pause_advertise(pause), .ability_advertise(ability),
        .link_speed_100(speed), .link_full_duplex(duplex));
    pmr_host_model u_host (.clk(clk), .mdio_line(mdio_line), .mdc(mdc), .host_drive(host_drive),
        .rd_valid(rd_valid), .rd_data(rd_data));

    task automatic stop_test;
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input [15:0] exp, input [15:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_reg(input [4:0] pa, input [4:0] ra, input [15:0] exp);
        exp_q.push_back(exp);
        u_host.frame(2'h2, pa, ra, 16'h0000, d);
    endtask
    task automatic wr_reg(input [4:0] pa, input [4:0] ra, input [15:0] wd);
        u_host.frame(2'h1, pa, ra, wd, d);
        if (pa == PA && ra == 5'h00 && wd[9]) exp_restarts++;
    endtask
    // Control levels packed with advertisement and resolved mode; forced speed is fixed at 100.
    task automatic chk_outs;
        repeat (3) @(posedge clk);
        chk("port outputs", {ctl[12], ctl[9], ctl[8], ctl[5:0], adv[10], adv[8:5],
            ctl[12] ? (adv[8] | adv[7]) : 1'b1, ctl[12] ? (adv[8] | (!adv[7] & adv[6])) : ctl[8]},
            {neg_en, reneg, full, alg, pair, xoff, fault_off, tx_off, led_off, pause, ability, speed, duplex});
    endtask

    // Each read answer is matched against the oldest expectation.
    always @(posedge clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) chk("unexpected read", 16'h0000, 16'hffff);
            else chk("read data", exp_q.pop_front(), rd_data);
        end
    end
    always @(posedge clk) if (restart === 1'b1) restarts++;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            err_count++;
            $display("timeout");
            stop_test;
        end
    end

    initial begin
        err_count = 0; checked = 0; exp_restarts = 0;
        rst = 1'b1; link_up = 1'b0; negotiation_done = 1'b0; remote_fault = 1'b0;
        void'($urandom(32'h2263));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        ctl = 16'h1120;
        adv = 16'h0de1;
        chk_outs;
        rd_reg(PA, 5'h00, ctl);
        rd_reg(PA, 5'h01, 16'h7808);
        rd_reg(PA, 5'h02, 16'h0a5c);
        rd_reg(PA, 5'h03, 16'h3c70);
        rd_reg(PA, 5'h04, adv);
        $display("test reset_values done");
        // Random writes; bit 12 and bit 9 are steered so both levels of each occur.
        for (i = 0; i < 6; i++) begin
            w = 16'($urandom);
            w[12] = i[0];
            w[9] = i[1];
            wr_reg(PA, 5'h00, w);
            ctl = w & 16'h133f;
            w = 16'($urandom);
            wr_reg(PA, 5'h04, w);
            adv = 16'h0801 | (w & 16'h07e0);
            ls = 3'($urandom);
            link_up <= ls[0];
            negotiation_done <= ls[1];
            remote_fault <= ls[2];
            rd_reg(PA, 5'h00, ctl);
            rd_reg(PA, 5'h04, adv);
            rd_reg(PA, 5'h01, 16'h7808 | {ls[1], ls[2] & !ctl[2], 1'b0, ls[0], 2'b00});
            chk_outs;
        end
        $display("test random_access done");
        wr_reg(5'h05, 5'h00, 16'h0000);
        wr_reg(5'h01, 5'h04, 16'h0000);
        rd_reg(5'h03, 5'h00, 16'hffff);
        wr_reg(PA, 5'h02, 16'h0000);
        wr_reg(PA, 5'h01, 16'h0000);
        rd_reg(PA, 5'h02, 16'h0a5c);
        rd_reg(PA, 5'h1f, 16'h0000);
        rd_reg(PA, 5'h00, ctl);
        rd_reg(PA, 5'h04, adv);
        chk("restart pulses", exp_restarts[15:0], restarts[15:0]);
        $display("test refusals done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        ctl = 16'h1120;
        adv = 16'h0de1;
        chk_outs;
        rd_reg(PA, 5'h00, ctl);
        $display("test second_reset done");
        stop_test;
    end
endmodule // tb

// [rtl/pmr_defs.vh]
`ifndef PMR_DEFS_VH
`define PMR_DEFS_VH

// Register indices on the management serial interface.
`define PMR_REG_CONTROL      5'h00
`define PMR_REG_STATUS       5'h01
`define PMR_REG_ID_UPPER     5'h02
`define PMR_REG_ID_LOWER     5'h03
`define PMR_REG_ADVERT       5'h04

// Control register field positions.
`define PMR_CTL_NEG_ENABLE   12
`define PMR_CTL_RENEGOTIATE  9
`define PMR_CTL_FULL_DUPLEX  8
`define PMR_CTL_XOVER_ALG    5
`define PMR_CTL_FIXED_PAIR   4
`define PMR_CTL_XOVER_OFF    3
`define PMR_CTL_FAULT_OFF    2
`define PMR_CTL_TX_OFF       1
`define PMR_CTL_LED_OFF      0

// Status register field positions.
`define PMR_STS_T4           15
`define PMR_STS_100F         14
`define PMR_STS_100H         13
`define PMR_STS_10F          12
`define PMR_STS_10H          11
`define PMR_STS_NEG_DONE     5
`define PMR_STS_FAULT        4
`define PMR_STS_NEG_SUPP     3
`define PMR_STS_LINK         2
`define PMR_STS_EXT          0

// Advertisement register field positions.
`define PMR_ADV_PAUSE        10
`define PMR_ADV_RSVD9        9
`define PMR_ADV_100F         8
`define PMR_ADV_10H          5
`define PMR_ADV_FIXED_HI     2'h1
`define PMR_ADV_SELECTOR     5'h01

// Reset values of the writable fields.
`define PMR_RST_NEG_ENABLE   1'b1
`define PMR_RST_RENEGOTIATE  1'b0
`define PMR_RST_FULL_DUPLEX  1'b1
`define PMR_RST_XOVER_ALG    1'b1
`define PMR_RST_FIXED_PAIR   1'b0
`define PMR_RST_XOVER_OFF    1'b0
`define PMR_RST_FAULT_OFF    1'b0
`define PMR_RST_TX_OFF       1'b0
`define PMR_RST_LED_OFF      1'b0
`define PMR_RST_PAUSE        1'b1
`define PMR_RST_RSVD9        1'b0
`define PMR_RST_ABILITY      4'hf

// Serial frame layout and timing counts.
`define PMR_PREAMBLE_BITS    6'd32
`define PMR_HDR_BITS         5'd12
`define PMR_DATA_BITS        5'd16
`define PMR_OP_READ          2'h2
`define PMR_OP_WRITE         2'h1
`define PMR_SYNC_STAGES      3

`endif

// [rtl/pmr_register_set.v]
// Operation
// - Writing one to control bit 9 restarts negotiation; resets to zero.
// - Control bit 8 selects forced duplex, one full; resets to one.
// - Control bit 5 picks the crossover algorithm; one, the reset value, is compatible scheme.
// - With crossover off, control bit 4 one gives straight, zero crossed.
// - Control bit 3 one disables automatic crossover; resets to zero.
// - Control bit 2 one disables remote fault detection; resets to zero.
// - Control bit 1 one stops the transmitter; resets to zero.
// - Control bit 0 one switches the indicator LED off; resets to zero.
// - Status reads four speed/duplex capabilities as one; four-pair and extended read zero.
// - Status bit 5 reads one once negotiation has completed.
// - Status bit 4 reads one when a remote fault is detected.
// - Status bit 3 always reads one: negotiation is supported.
// - Status bit 2 reads one while the link is up.
// - Fixed identifier reads as two halves, upper at index 2, lower at 3.
// - Advertisement bit 10 offers pause; read-write, resets to one.
// - Advertisement bits 8 to 5 offer the four abilities; read-write, reset one.
// - Control bit 12 enables negotiation; resets to one.
// - The port answers at management address PORT_NUMBER, 0x1 by default.
`timescale 1ns/1ns
`include "pmr_defs.vh"

module pmr_register_set #(
    parameter [4:0]  PORT_NUMBER    = 5'h01,
    parameter [15:0] ID_UPPER       = 16'h0a5c,  // Arbitrary value.
    parameter [15:0] ID_LOWER       = 16'h3c70,  // Arbitrary value.
    parameter        FORCED_SPEED_100 = 1'b1
) (
    // Clock and reset.
    input  wire        clk,
    input  wire        rst,
    // Management serial pins.
    input  wire        mdc,
    input  wire        mdio_in,
    output reg         mdio_out,
    output reg         mdio_oe,
    // Port state from the transceiver core.
    input  wire        link_up,
    input  wire        negotiation_done,
    input  wire        remote_fault,
    // Control towards the transceiver core.
    output reg         negotiation_enable,
    output reg         renegotiate_request,
    output reg         negotiation_restart,
    output reg         forced_full_duplex,
    output reg         crossover_algorithm_select,
    output reg         fixed_pair_assignment,
    output reg         auto_crossover_off,
    output reg         remote_fault_detect_off,
    output reg         transmit_off,
    output reg         indicator_off,
    // Advertised abilities and resolved mode.
    output reg         pause_advertise,
    output reg  [3:0]  ability_advertise,
    output reg         link_speed_100,
    output reg         link_full_duplex
);

    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_START = 3'd1;
    localparam [2:0] ST_HDR   = 3'd2;
    localparam [2:0] ST_TA    = 3'd3;
    localparam [2:0] ST_DATA  = 3'd4;

    // Synchronised pin levels.
    wire        mdc_level;
    wire        mdio_level;
    reg         mdc_prev;
    wire        bit_tick;

    // Frame decoder state.
    reg  [2:0]  state;
    reg  [5:0]  pre_count;
    reg  [4:0]  bit_count;
    reg  [11:0] header;
    reg  [15:0] shifter;
    reg         is_read;
    reg         adv_rsvd9;
    reg         write_strobe;
    reg  [4:0]  write_index;
    reg  [15:0] write_data;

    // Register read composition.
    wire [15:0] control_word;
    wire [15:0] status_word;
    wire [15:0] advert_word;
    wire        addr_match;
    wire [1:0]  hdr_op;
    wire [4:0]  hdr_reg;

    // Returns the read value of a register index, zero for unmapped indices.
    function [15:0] read_mux;
        input [4:0]  index;
        input [15:0] ctl;
        input [15:0] sts;
        input [15:0] adv;
        begin
            case (index)
                `PMR_REG_CONTROL:  read_mux = ctl;
                `PMR_REG_STATUS:   read_mux = sts;
                `PMR_REG_ID_UPPER: read_mux = ID_UPPER;
                `PMR_REG_ID_LOWER: read_mux = ID_LOWER;
                `PMR_REG_ADVERT:   read_mux = adv;
                default:           read_mux = 16'h0000;
            endcase
        end
    endfunction

    // Both the clock and data pins come from the management host, outside our domain.
    pmr_sync u_sync_mdc (
        .clk      (clk),
        .rst      (rst),
        .async_in (mdc),
        .level    (mdc_level)
    );

    pmr_sync u_sync_mdio (
        .clk      (clk),
        .rst      (rst),
        .async_in (mdio_in),
        .level    (mdio_level)
    );

    // The serial clock is sampled, not used as a clock, so each rising edge becomes one enable pulse.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mdc_prev <= 1'b1;
        end else begin
            mdc_prev <= mdc_level;
        end
    end

    assign bit_tick = mdc_level & ~mdc_prev;

    assign hdr_op     = header[11:10];
    assign hdr_reg    = header[4:0];
    assign addr_match = (header[9:5] == PORT_NUMBER);

    // Control word; bits 15 to 13, 11, 10, 7 and 6 read as zero.
    assign control_word = {3'b000,
                           negotiation_enable,
                           2'b00,
                           renegotiate_request,
                           forced_full_duplex,
                           2'b00,
                           crossover_algorithm_select,
                           fixed_pair_assignment,
                           auto_crossover_off,
                           remote_fault_detect_off,
                           transmit_off,
                           indicator_off};

    // Status word built live from the core's state.
    assign status_word = {1'b0,
                          4'hf,
                          4'h0,
                          1'b0,
                          negotiation_done,
                          remote_fault & ~remote_fault_detect_off,
                          1'b1,
                          link_up,
                          1'b0,
                          1'b0};

    // Advertisement word with its fixed upper field and selector.
    assign advert_word = {3'b000,
                          `PMR_ADV_FIXED_HI,
                          pause_advertise,
                          adv_rsvd9,
                          ability_advertise,
                          `PMR_ADV_SELECTOR};

    // Frame decoder: preamble of ones, start 01, opcode, addresses, turnaround, data.
    // Read data changes just after the host's rising edge has been seen, which leaves the
    // rest of the serial period for the host to sample it on the next rising edge.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state        <= ST_IDLE;
            pre_count    <= 6'd0;
            bit_count    <= 5'd0;
            header       <= 12'h000;
            shifter      <= 16'h0000;
            is_read      <= 1'b0;
            mdio_out     <= 1'b0;
            mdio_oe      <= 1'b0;
            write_strobe <= 1'b0;
            write_index  <= 5'h00;
            write_data   <= 16'h0000;
        end else begin
            write_strobe <= 1'b0;
            if (bit_tick) begin
                case (state)
                    ST_IDLE: begin
                        if (mdio_level) begin
                            if (pre_count != `PMR_PREAMBLE_BITS) begin
                                pre_count <= pre_count + 6'd1;
                            end
                        end else if (pre_count == `PMR_PREAMBLE_BITS) begin
                            state <= ST_START;
                        end else begin
                            pre_count <= 6'd0;
                        end
                    end
                    ST_START: begin
                        pre_count <= 6'd0;
                        bit_count <= 5'd0;
                        state     <= mdio_level ? ST_HDR : ST_IDLE;
                    end
                    ST_HDR: begin
                        header    <= {header[10:0], mdio_level};
                        bit_count <= bit_count + 5'd1;
                        if (bit_count == `PMR_HDR_BITS - 5'd1) begin
                            bit_count <= 5'd0;
                            state     <= ST_TA;
                        end
                    end
                    ST_TA: begin
                        bit_count <= bit_count + 5'd1;
                        if (bit_count == 5'd0) begin
                            is_read <= (hdr_op == `PMR_OP_READ);
                            if ((hdr_op == `PMR_OP_READ) && addr_match) begin
                                // Drive the second turnaround bit low.
                                mdio_out <= 1'b0;
                                mdio_oe  <= 1'b1;
                                shifter  <= read_mux(hdr_reg, control_word, status_word, advert_word);
                            end else if ((hdr_op != `PMR_OP_READ) && (hdr_op != `PMR_OP_WRITE)) begin
                                state <= ST_IDLE;
                            end
                        end else begin
                            bit_count <= 5'd0;
                            state     <= ST_DATA;
                            if (mdio_oe) begin
                                mdio_out <= shifter[15];
                                shifter  <= {shifter[14:0], 1'b0};
                            end
                        end
                    end
                    ST_DATA: begin
                        bit_count <= bit_count + 5'd1;
                        if (is_read) begin
                            mdio_out <= shifter[15];
                            shifter  <= {shifter[14:0], 1'b0};
                        end else begin
                            shifter <= {shifter[14:0], mdio_level};
                        end
                        if (bit_count == `PMR_DATA_BITS - 5'd1) begin
                            // Release the line after the last data bit.
                            mdio_oe  <= 1'b0;
                            mdio_out <= 1'b0;
                            state    <= ST_IDLE;
                            if (!is_read && addr_match) begin
                                write_strobe <= 1'b1;
                                write_index  <= hdr_reg;
                                write_data   <= {shifter[14:0], mdio_level};
                            end
                        end
                    end
                    default: begin
                        state   <= ST_IDLE;
                        mdio_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Writable fields; a write to an unmapped or read-only index is ignored.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            negotiation_enable         <= `PMR_RST_NEG_ENABLE;
            renegotiate_request        <= `PMR_RST_RENEGOTIATE;
            negotiation_restart        <= 1'b0;
            forced_full_duplex         <= `PMR_RST_FULL_DUPLEX;
            crossover_algorithm_select <= `PMR_RST_XOVER_ALG;
            fixed_pair_assignment      <= `PMR_RST_FIXED_PAIR;
            auto_crossover_off         <= `PMR_RST_XOVER_OFF;
            remote_fault_detect_off    <= `PMR_RST_FAULT_OFF;
            transmit_off               <= `PMR_RST_TX_OFF;
            indicator_off              <= `PMR_RST_LED_OFF;
            pause_advertise            <= `PMR_RST_PAUSE;
            adv_rsvd9                  <= `PMR_RST_RSVD9;
            ability_advertise          <= `PMR_RST_ABILITY;
        end else begin
            negotiation_restart <= 1'b0;
            if (write_strobe && (write_index == `PMR_REG_CONTROL)) begin
                negotiation_enable         <= write_data[`PMR_CTL_NEG_ENABLE];
                renegotiate_request        <= write_data[`PMR_CTL_RENEGOTIATE];
                negotiation_restart        <= write_data[`PMR_CTL_RENEGOTIATE];
                forced_full_duplex         <= write_data[`PMR_CTL_FULL_DUPLEX];
                crossover_algorithm_select <= write_data[`PMR_CTL_XOVER_ALG];
                fixed_pair_assignment      <= write_data[`PMR_CTL_FIXED_PAIR];
                auto_crossover_off         <= write_data[`PMR_CTL_XOVER_OFF];
                remote_fault_detect_off    <= write_data[`PMR_CTL_FAULT_OFF];
                transmit_off               <= write_data[`PMR_CTL_TX_OFF];
                indicator_off              <= write_data[`PMR_CTL_LED_OFF];
            end
            if (write_strobe && (write_index == `PMR_REG_ADVERT)) begin
                pause_advertise   <= write_data[`PMR_ADV_PAUSE];
                adv_rsvd9         <= write_data[`PMR_ADV_RSVD9];
                ability_advertise <= write_data[`PMR_ADV_100F:`PMR_ADV_10H];
            end
        end
    end

    // Resolved mode: best advertised ability with negotiation on, forced settings with it off.
    // Without partner abilities in this block, the advertised set stands in for the common set.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            link_speed_100   <= 1'b1;
            link_full_duplex <= 1'b1;
        end else if (!negotiation_enable) begin
            link_speed_100   <= FORCED_SPEED_100;
            link_full_duplex <= forced_full_duplex;
        end else begin
            link_speed_100   <= ability_advertise[3] | ability_advertise[2];
            link_full_duplex <= ability_advertise[3] | (~ability_advertise[2] & ability_advertise[1]);
        end
    end

endmodule // pmr_register_set

// [rtl/pmr_sync.v]
`timescale 1ns/1ns
// Three-stage synchroniser with a two-out-of-two agreement filter.
module pmr_sync (
    // Clock and reset.
    input  wire clk,
    input  wire rst,
    // Asynchronous input and filtered level.
    input  wire async_in,
    output reg  level
);

    reg stage1;
    reg stage2;
    reg stage3;

    // The first stage feeds only the second; the level moves once stages two and three agree.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= 1'b1;
            stage2 <= 1'b1;
            stage3 <= 1'b1;
            level  <= 1'b1;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level <= stage3;
            end
        end
    end

endmodule // pmr_sync
